// [src/oscc_pkg.sv]
/*
  shared constants and types for the on/off switch cycle controller.
  assumes a single 10 mhz system clock; all times become cycle counts here.
*/
package oscc_pkg;
  // ----------------------------------------
  // clock and oscillator
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;  // system clock rate
  localparam int unsigned CLK_PERIOD_NS = 100;         // system clock period
  localparam int unsigned OSC_FAST_HZ   = 264_000;     // base sampling rate
  // clocks per base oscillator tick; rounds down, so slightly fast
  localparam int unsigned OSC_TICK_CYC  = CLK_HZ / OSC_FAST_HZ;
  localparam int unsigned DMAX_PCT      = 65;          // max duty share
  localparam int unsigned DMAX_FAST_CYC = OSC_TICK_CYC * DMAX_PCT / 100;
  localparam int unsigned DMAX_SLOW_CYC = 2 * OSC_TICK_CYC * DMAX_PCT / 100;
  // blanking after turn-on, rounded up to whole clocks
  localparam int unsigned BLANKING_INTERVAL_NS = 220;
  localparam int unsigned BLANK_CYC =
    (BLANKING_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // auto-restart and current-limit stepping
  // ----------------------------------------
  localparam int unsigned AR_SW_CYCLES = 8192;         // cycles without low
  localparam int unsigned AR_OFF_MS    = 1000;         // off time
  localparam int unsigned AR_OFF_CYC   = AR_OFF_MS * (CLK_HZ / 1000);
  localparam logic [2:0]  LVL_UP_RUN   = 3'h4;         // enables to step up
  localparam logic [2:0]  LVL_DN_RUN   = 3'h7;         // skips to step down
  localparam logic [1:0]  LVL_MAX      = 2'h3;         // peak level
  localparam logic [1:0]  LVL_MIN      = 2'h0;
  localparam logic [1:0]  LVL_RESET    = 2'h3;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_0004;
  localparam int          CTRL_EXT     = 0;            // extension allowed
  localparam logic        CTRL_EXT_RST = 1'b1;
  localparam int          ST_SW        = 0;            // switch on
  localparam int          ST_LVL       = 1;            // two-bit level
  localparam int          ST_EXT       = 3;            // extension active
  localparam int          ST_SUP       = 4;            // supply good
  localparam int          ST_HOT       = 5;            // thermal shutdown
  localparam int          ST_AR        = 6;            // auto-restart off
  localparam int          ST_LUV       = 7;            // line undervoltage

  typedef enum logic [1:0] {CY_IDLE, CY_ON, CY_REST} oscc_cy_state_type;
  typedef enum logic {AR_RUN, AR_OFF} oscc_ar_state_type;
endpackage

// [src/oscc_sync.sv]
/*
  two-flop synchroniser, one chain per bit.
  assumes inputs are slow comparator levels, not pulses.
*/
`timescale 1ns/1ns
module oscc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  // ----------------------------------------
  // per-bit chains
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;  // first stage, read only by the second
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r <= 1'b0;
          q[i]   <= 1'b0;
        end
        else
        begin
          meta_r <= d[i];
          q[i]   <= meta_r;
        end
      end
    end
  endgenerate
endmodule

// [src/oscc_ctrl.sv]
/*
  on/off switch cycle controller: oscillator, cycle gate, current-limit
  level machine, protection and auto-restart, plus an ahb-lite slave.
  assumes comparator outputs arrive as levels and hsel decodes the block.
*/
`timescale 1ns/1ns
module oscc_ctrl #(
  parameter int unsigned AR_SW_CYCLES = oscc_pkg::AR_SW_CYCLES,
  parameter int unsigned AR_OFF_CYC   = oscc_pkg::AR_OFF_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  // comparator levels
  input  wire logic        feedback_line_sense_input,
  input  wire logic        cur_limit_trip,
  input  wire logic        supply_below_low,
  input  wire logic        supply_at_reg,
  input  wire logic        temp_above_trip,
  input  wire logic        temp_recovered,
  input  wire logic        line_uv_sense,
  input  wire logic        line_res_absent,
  // switch and analog controls
  output      logic        switch_gate,
  output      logic [1:0]  cur_limit_level,
  output      logic        osc_double,
  output      logic        supply_select_node_hold
);
  localparam int OSC_A = oscc_pkg::OSC_TICK_CYC;  // clocks between ticks, for checks

  // ----------------------------------------
  // synchronised inputs
  // ----------------------------------------
  logic [7:0] sync_q;   // synchronised comparator levels
  logic       en_s;     // enable circuit output, high = enable
  logic       trip_s;   // sensed current above active limit
  logic       low_s;    // supply below lower threshold
  logic       reg_s;    // supply back at regulation
  logic       hot_s;    // die above shutdown threshold
  logic       cool_s;   // die cooled by the hysteresis
  logic       luv_s;    // line-sense current below threshold
  logic       nores_s;  // almost no line-sense current

  // comparator levels would otherwise race the cycle logic
  oscc_sync #(.W(8)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({line_res_absent, line_uv_sense, temp_recovered,
             temp_above_trip, supply_at_reg, supply_below_low,
             cur_limit_trip, feedback_line_sense_input}),
    .q     (sync_q)
  );
  // the optocoupler pulling current shows here as a low level
  assign {nores_s, luv_s, cool_s, hot_s, reg_s, low_s, trip_s, en_s} = sync_q;

  // ----------------------------------------
  // state
  // ----------------------------------------
  oscc_pkg::oscc_cy_state_type cy_st_r;    // cycle state
  oscc_pkg::oscc_cy_state_type cy_nxt;
  oscc_pkg::oscc_ar_state_type ar_st_r;    // auto-restart state
  logic [5:0]  osc_cnt_r;      // base tick divider
  logic        ticks_left_r;   // extra tick in a slow cycle
  logic        slow_r;         // current cycle is half rate
  logic [6:0]  cyc_cnt_r;      // clocks since cycle start
  logic [1:0]  lvl_r;          // current-limit level
  logic [2:0]  up_run_r;       // consecutive enabled samples
  logic [2:0]  dn_run_r;       // consecutive skipped samples
  logic [13:0] ar_cnt_r;       // cycles since last low enable
  logic [23:0] off_cnt_r;      // clocks spent off in auto-restart
  logic        sup_ok_r;       // internal supply usable
  logic        therm_r;        // thermal shutdown active
  logic        uv_gate_r;      // line undervoltage still gates start
  logic        ext_block_r;    // extension held off
  logic        ext_allow_r;    // software permits extension
  logic        switch_on_r;
  logic        osc_double_r;
  logic        hold_r;
  // combinational helpers
  logic        tick;           // last clock of a base period
  logic        boundary;       // a cycle may begin here
  logic        luv;            // effective line undervoltage
  logic        sw_allow;       // protections permit a start
  logic        start;          // a conduction cycle begins
  logic        ext_active;     // on-time extension in force
  logic        max_duty_signal;
  logic        blank_done;
  logic        off_now;        // conduction ends this clock
  logic        ar_enter;       // fault timeout reached

  // ----------------------------------------
  // oscillator
  // ----------------------------------------
  // base divider always runs; slow cycles simply span two ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      osc_cnt_r <= 6'h00;
    else if (tick)
      osc_cnt_r <= 6'h00;
    else
      osc_cnt_r <= osc_cnt_r + 6'h01;
  end

  assign tick       = (osc_cnt_r == 6'(oscc_pkg::OSC_TICK_CYC - 1));
  // idle resamples every base tick, not every slow period
  assign boundary   = tick && (cy_st_r == oscc_pkg::CY_IDLE || !ticks_left_r);
  assign luv        = luv_s && !nores_s;
  // undervoltage matters only until switching is running
  assign sw_allow   = sup_ok_r && !therm_r && ar_st_r == oscc_pkg::AR_RUN
                      && !(uv_gate_r && luv);
  assign start      = boundary && en_s && sw_allow;
  assign ext_active = ext_allow_r && !ext_block_r;
  assign max_duty_signal = slow_r ? (cyc_cnt_r < 7'(oscc_pkg::DMAX_SLOW_CYC))
                                  : (cyc_cnt_r < 7'(oscc_pkg::DMAX_FAST_CYC));
  assign blank_done = cyc_cnt_r >= 7'(oscc_pkg::BLANK_CYC);
  assign off_now    = (trip_s && blank_done)
                      || (!ext_active && !max_duty_signal);

  // ----------------------------------------
  // cycle gate
  // ----------------------------------------
  // once started, the limit, max duty without extension, or a boundary without a start ends conduction
  always_comb
  begin
    cy_nxt = cy_st_r;
    if (boundary)
      cy_nxt = start ? oscc_pkg::CY_ON : oscc_pkg::CY_IDLE;
    else if (cy_st_r == oscc_pkg::CY_ON && off_now)
      cy_nxt = oscc_pkg::CY_REST;
  end

  // state, tick budget and in-cycle clock count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cy_st_r      <= oscc_pkg::CY_IDLE;
      switch_on_r  <= 1'b0;
      ticks_left_r <= 1'b0;
      slow_r       <= 1'b0;
      cyc_cnt_r    <= 7'h00;
    end
    else
    begin
      cy_st_r     <= cy_nxt;
      switch_on_r <= (cy_nxt == oscc_pkg::CY_ON);
      if (start)
      begin
        // rate is latched so a level change cannot stretch a cycle
        slow_r       <= (lvl_r != oscc_pkg::LVL_MAX);
        ticks_left_r <= (lvl_r != oscc_pkg::LVL_MAX);
        cyc_cnt_r    <= 7'h00;
      end
      else
      begin
        if (tick)
          ticks_left_r <= 1'b0;
        if (cyc_cnt_r != 7'h7F)
          cyc_cnt_r <= cyc_cnt_r + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // current-limit level machine
  // ----------------------------------------
  // runs of enables step up, runs of skips step down
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_r    <= oscc_pkg::LVL_RESET;
      up_run_r <= 3'h0;
      dn_run_r <= 3'h0;
    end
    else if (boundary && en_s)
    begin
      dn_run_r <= 3'h0;
      if (up_run_r == oscc_pkg::LVL_UP_RUN - 3'h1)
      begin
        up_run_r <= 3'h0;
        if (lvl_r != oscc_pkg::LVL_MAX)
          lvl_r <= lvl_r + 2'h1;
      end
      else
        up_run_r <= up_run_r + 3'h1;
    end
    else if (boundary)
    begin
      up_run_r <= 3'h0;
      if (dn_run_r == oscc_pkg::LVL_DN_RUN - 3'h1)
      begin
        dn_run_r <= 3'h0;
        if (lvl_r != oscc_pkg::LVL_MIN)
          lvl_r <= lvl_r - 2'h1;
      end
      else
        dn_run_r <= dn_run_r + 3'h1;
    end
  end

  // ----------------------------------------
  // supply and thermal protection
  // ----------------------------------------
  // hysteresis lives in the comparators; here only set and clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sup_ok_r <= 1'b0;
      therm_r  <= 1'b0;
    end
    else
    begin
      if (low_s)
        sup_ok_r <= 1'b0;
      else if (reg_s)
        sup_ok_r <= 1'b1;
      if (hot_s)
        therm_r <= 1'b1;
      else if (cool_s)
        therm_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // auto-restart
  // ----------------------------------------
  assign ar_enter = ar_st_r == oscc_pkg::AR_RUN && boundary && en_s
                    && ar_cnt_r == 14'(AR_SW_CYCLES - 1);

  // counts cycles without a low sample, then times the off period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ar_st_r   <= oscc_pkg::AR_RUN;
      ar_cnt_r  <= 14'h0000;
      off_cnt_r <= 24'h000000;
    end
    else if (!sup_ok_r)
    begin
      ar_st_r  <= oscc_pkg::AR_RUN;
      ar_cnt_r <= 14'h0000;
    end
    else if (ar_st_r == oscc_pkg::AR_RUN)
    begin
      if (ar_enter)
      begin
        ar_st_r   <= oscc_pkg::AR_OFF;
        off_cnt_r <= 24'h000000;
      end
      else if (boundary && !en_s)
        ar_cnt_r <= 14'h0000;
      else if (boundary)
        ar_cnt_r <= ar_cnt_r + 14'h0001;
    end
    else if (!luv)
    begin
      // undervoltage freezes the count and so stretches the off time
      if (off_cnt_r == 24'(AR_OFF_CYC - 1))
      begin
        ar_st_r  <= oscc_pkg::AR_RUN;
        ar_cnt_r <= 14'h0000;
      end
      else
        off_cnt_r <= off_cnt_r + 24'h000001;
    end
  end

  // ----------------------------------------
  // start gating and extension blocking
  // ----------------------------------------
  // both rearm on power-up and on each auto-restart
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uv_gate_r   <= 1'b1;
      ext_block_r <= 1'b1;
    end
    else if (!sup_ok_r || ar_enter)
    begin
      uv_gate_r   <= 1'b1;
      ext_block_r <= 1'b1;
    end
    else
    begin
      if (start)
        uv_gate_r <= 1'b0;
      // a low sample means the output has reached regulation
      if (boundary && !en_s && ar_st_r == oscc_pkg::AR_RUN)
        ext_block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // analog control outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_double_r <= 1'b1;
      hold_r       <= 1'b0;
    end
    else
    begin
      osc_double_r <= (lvl_r == oscc_pkg::LVL_MAX);
      hold_r       <= uv_gate_r && luv;
    end
  end

  assign switch_gate             = switch_on_r;
  assign cur_limit_level         = lvl_r;
  assign osc_double              = osc_double_r;
  assign supply_select_node_hold = hold_r;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic        wr_pend_r;  // word write awaiting its data phase
  logic [31:0] wr_addr_r;
  logic        ap_take;    // address phase accepted
  logic [31:0] rd_w;       // read value at address time

  assign ap_take = hsel && htrans[1] && hready;

  // status is a snapshot at the address edge; ctrl forwards a write
  always_comb
  begin
    rd_w = 32'h0000_0000;
    if (haddr == oscc_pkg::ADDR_CTRL)
      rd_w[oscc_pkg::CTRL_EXT] = (wr_pend_r && wr_addr_r == oscc_pkg::ADDR_CTRL)
                                 ? hwdata[oscc_pkg::CTRL_EXT] : ext_allow_r;
    else if (haddr == oscc_pkg::ADDR_STATUS)
    begin
      rd_w[oscc_pkg::ST_SW]        = switch_on_r;
      rd_w[oscc_pkg::ST_LVL +: 2]  = lvl_r;
      rd_w[oscc_pkg::ST_EXT]       = ext_active;
      rd_w[oscc_pkg::ST_SUP]       = sup_ok_r;
      rd_w[oscc_pkg::ST_HOT]       = therm_r;
      rd_w[oscc_pkg::ST_AR]        = (ar_st_r == oscc_pkg::AR_OFF);
      rd_w[oscc_pkg::ST_LUV]       = luv;
    end
  end

  // zero wait states; unmapped reads give zero, writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 32'h0000_0000;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
      ext_allow_r <= oscc_pkg::CTRL_EXT_RST;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (wr_pend_r && wr_addr_r == oscc_pkg::ADDR_CTRL)
        ext_allow_r <= hwdata[oscc_pkg::CTRL_EXT];
      if (hready)
      begin
        wr_pend_r <= ap_take && hwrite && hsize == 3'h2;
        wr_addr_r <= haddr;
      end
      if (ap_take && !hwrite)
        hrdata <= rd_w;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_blanked_on;
    switch_on_r [*4];
  endsequence

  start_gate_a: assert property (start |=> switch_on_r)
    else $error("enabled start did not turn the switch on");
  skip_gate_a: assert property (boundary && !en_s |=> !switch_on_r)
    else $error("switch on after a disabled sample");
  cycle_hold_a: assert property (
    cy_st_r != oscc_pkg::CY_IDLE && !boundary |=> cy_st_r != oscc_pkg::CY_IDLE)
    else $error("cycle ended before its boundary");
  fast_resample_a: assert property (
    boundary && !start |=> ##[1:OSC_A] boundary)
    else $error("skipped cycle not resampled at base rate");
  level_step_a: assert property (
    boundary && !en_s && dn_run_r == oscc_pkg::LVL_DN_RUN - 3'h1
    && lvl_r != oscc_pkg::LVL_MIN |=> lvl_r == $past(lvl_r) - 2'h1)
    else $error("level did not step down");
  limit_off_a: assert property (
    cy_st_r == oscc_pkg::CY_ON && trip_s && blank_done && !boundary
    |=> !switch_on_r)
    else $error("current limit did not end conduction");
  blank_hold_a: assert property ($rose(switch_on_r) |-> s_blanked_on)
    else $error("pulse ended inside blanking");
  supply_block_a: assert property (boundary && !sup_ok_r |=> !switch_on_r)
    else $error("start with supply not good");
  thermal_block_a: assert property (boundary && therm_r |=> !switch_on_r)
    else $error("start during thermal shutdown");
  restart_clear_a: assert property (
    boundary && !en_s && sup_ok_r && ar_st_r == oscc_pkg::AR_RUN
    |=> ar_cnt_r == 14'h0000)
    else $error("restart counter not cleared");
  restart_halt_a: assert property (
    sup_ok_r && ar_st_r == oscc_pkg::AR_OFF && luv
    |=> ar_st_r == oscc_pkg::AR_OFF && $stable(off_cnt_r))
    else $error("off counter ran during undervoltage");
  duty_end_a: assert property (
    cy_st_r == oscc_pkg::CY_ON && !ext_active && !max_duty_signal && !boundary
    |=> !switch_on_r)
    else $error("conduction past max duty without extension");
  ext_block_a: assert property (ar_st_r == oscc_pkg::AR_OFF |-> !ext_active)
    else $error("extension active in auto-restart");
  peak_rate_a: assert property (start && lvl_r == oscc_pkg::LVL_MAX |=> !slow_r)
    else $error("peak level cycle not at double rate");
endmodule

// [dv/oscc_opto_model.sv]
/*
  secondary-side optocoupler model driving the enable comparator level.
  assumes the bench says when the output sits above target.
*/
`timescale 1ns/1ns
module oscc_opto_model (
  // clock
  input  wire logic hclk,
  // secondary side: high when output above target, slow selects lag
  input  wire logic above_target,
  input  wire logic slow,
  // enable level toward the device
  output      logic feedback_line_sense_input
);
  logic [2:0] lag_r;  // led and transistor lag, three clocks
  // ----------------------------------------
  // pulling current means disable
  // ----------------------------------------
  always_ff @(posedge hclk)
  begin
    lag_r <= {lag_r[1:0], above_target};
  end
  assign feedback_line_sense_input = !(slow ? lag_r[2] : above_target);
endmodule

// [dv/onoff_switch_cycle_controller_tb.sv]
/*
  self-checking bench for the switch cycle controller top.
  assumes 10 mhz clock and shortened auto-restart counts.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module onoff_switch_cycle_controller_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0, cur_limit_level;
  logic [2:0]  hsize = 3'h2;
  logic hreadyout, hresp, en, switch_gate, osc_double, hold;
  logic trip = 1'b0, below = 1'b0, at_reg = 1'b0, hot = 1'b0, cool = 1'b0;
  logic luv = 1'b0, above = 1'b0, slow = 1'b0, nores = 1'b0;
  int fails = 0, compares = 0, cyc = 0;
  always #50 hclk = ~hclk;  // 10 mhz
  oscc_opto_model opto (.hclk(hclk), .above_target(above), .slow(slow),
    .feedback_line_sense_input(en));
  oscc_ctrl #(.AR_SW_CYCLES(8), .AR_OFF_CYC(200)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .feedback_line_sense_input(en), .cur_limit_trip(trip),
    .supply_below_low(below), .supply_at_reg(at_reg), .temp_above_trip(hot),
    .temp_recovered(cool), .line_uv_sense(luv), .line_res_absent(nores),
    .switch_gate(switch_gate), .cur_limit_level(cur_limit_level),
    .osc_double(osc_double), .supply_select_node_hold(hold));
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d; hsel <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // bounded wait for the gate level, then judge it
  task wait_gate(input logic v, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      if (switch_gate === v) break;
    end
    `CHK(switch_gate, v)
  endtask
  task hold_low(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      `CHK(switch_gate, 1'b0)
    end
  endtask
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;  // reset values, write-back, unmapped read
    ahb(1'b0, 32'h0, 32'h0); `CHK(q, 32'h1)
    ahb(1'b1, 32'h0, 32'h0); ahb(1'b0, 32'h0, 32'h0); `CHK(q, 32'h0)
    ahb(1'b1, 32'h0, 32'h1); ahb(1'b0, 32'h8, 32'h0); `CHK(q, 32'h0)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    `CHK(cur_limit_level, oscc_pkg::LVL_RESET)
  endtask
  task t_start;  // enabled start ends at max duty, no extension yet
    wait_gate(1'b1, 80);
    repeat (20) @(posedge hclk);
    `CHK(switch_gate, 1'b1)
    wait_gate(1'b0, 8);
  endtask
  task t_trip;  // limit masked while blanking, then ends the cycle
    wait_gate(1'b1, 80);
    trip <= 1'b1; above <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(switch_gate, 1'b1)
    wait_gate(1'b0, 6);
    above <= 1'b0;
    hold_low(20);
    trip <= 1'b0;
  endtask
  task t_skip;  // disabled cycles, level steps down, fast resample
    slow <= 1'b1; above <= 1'b1;
    hold_low(300);
    `CHK(cur_limit_level, 2'h2)
    `CHK(osc_double, 1'b0)
    above <= 1'b0;
    // a wait for the full slow period would take about 74 clocks
    wait_gate(1'b1, 20);
  endtask
  task t_thermal;
    hot <= 1'b1;
    repeat (60) @(posedge hclk);
    // running slow cycle is past max duty, held by extension
    `CHK(switch_gate, 1'b1)
    repeat (20) @(posedge hclk);
    hold_low(150);
    hot <= 1'b0; cool <= 1'b1;
    wait_gate(1'b1, 500);
    cool <= 1'b0;
  endtask
  task t_supply;  // must climb back to regulation before switching
    at_reg <= 1'b0; below <= 1'b1; repeat (80) @(posedge hclk);
    hold_low(100);
    below <= 1'b0;
    hold_low(50);
    at_reg <= 1'b1;
    luv <= 1'b1;
    hold_low(80);
    `CHK(hold, 1'b1)
    // resistor reported absent: undervoltage no longer gates the start
    nores <= 1'b1;
    wait_gate(1'b1, 100);
    `CHK(hold, 1'b0)
    luv <= 1'b0;
    nores <= 1'b0;
  endtask
  task t_restart;  // no low samples: off period, stretched by line uv
    int run;
    run = 0;
    repeat (1500)
    begin
      @(posedge hclk);
      run = (switch_gate === 1'b0) ? run + 1 : 0;
      if (run == 120) break;
    end
    `CHK(run, 120)
    luv <= 1'b1;
    hold_low(300);
    // supply ok, restart off, line undervoltage seen, no extension
    ahb(1'b0, 32'h4, 32'h0);
    `CHK(q & 32'hF9, 32'hD0)
    luv <= 1'b0;
    // a halted off counter still owes time after the line recovers
    hold_low(40);
    wait_gate(1'b1, 400);
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    at_reg <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs; t_start; t_trip; t_skip; t_thermal; t_supply; t_restart;
    report_and_stop;
  end
endmodule
